// [hdl/psl_pkg.sv]
// constants and helpers for the phy status and link pulse block
package psl_pkg;

	localparam int CLK_MHZ            = 200;
	localparam int PULSE_WIDTH_NS     = 100;
	localparam int PULSE_GAP_SHORT_US = 62;
	localparam int PULSE_GAP_LONG_US  = 125;
	localparam int BURST_LEN_MS       = 2;
	localparam int BURST_PERIOD_MS    = 16;

	// least time, rounded up to whole cycles
	localparam int PULSE_WIDTH_CYC = (PULSE_WIDTH_NS * CLK_MHZ + 999) / 1000;
	localparam int GAP_SHORT_CYC   = PULSE_GAP_SHORT_US * CLK_MHZ;
	localparam int GAP_LONG_CYC    = PULSE_GAP_LONG_US * CLK_MHZ;
	localparam int BURST_LEN_CYC   = BURST_LEN_MS * 1000 * CLK_MHZ;
	localparam int BURST_PER_CYC   = BURST_PERIOD_MS * 1000 * CLK_MHZ;

	localparam int FRAME_W = 22;
	localparam int WIDTH_W = 8;

	localparam logic [15:0] REG_LPA      = 16'h0005;
	localparam logic [15:0] REG_EXT_CTL  = 16'h000d;
	localparam logic [15:0] REG_EXT_ADDR = 16'h000e;
	localparam logic [15:0] REG_STAT     = 16'h0010;
	localparam logic [15:0] REG_STRAP1   = 16'h006e;
	localparam logic [15:0] REG_STRAP2   = 16'h006f;

	localparam int STAT_LINK_BIT  = 0;
	localparam int STAT_10M_BIT   = 1;
	localparam int STAT_FDX_BIT   = 2;
	localparam int STAT_ANC_BIT   = 4;
	localparam int STAT_XOVER_BIT = 14;

	localparam logic [1:0]  EXT_FUNC_ADDR = 2'h0;
	localparam logic [15:0] LOCAL_ABILITY = 16'h01e1;
	localparam logic [4:0]  PHY_ADDR      = 5'h01;
	localparam logic [5:0]  PREAMBLE_LEN  = 6'h20;
	localparam logic [4:0]  HDR_LAST      = 5'h0c;
	localparam logic [4:0]  DATA_LAST     = 5'h0f;
	localparam logic [1:0]  OP_READ       = 2'h2;
	localparam logic [1:0]  OP_WRITE      = 2'h1;

	typedef enum logic [1:0] {
		MS_IDLE = 2'b00,
		MS_HDR  = 2'b01,
		MS_TA   = 2'b11,
		MS_DATA = 2'b10
	} psl_mdio_st_t;

	function automatic logic [15:0] psl_status_word(input logic link, input logic s100,
		input logic fdx, input logic anc, input logic xover);
		logic [15:0] w;
		w = 16'h0000;
		w[STAT_LINK_BIT]  = link;
		w[STAT_10M_BIT]   = !s100;
		w[STAT_FDX_BIT]   = fdx;
		w[STAT_ANC_BIT]   = anc;
		w[STAT_XOVER_BIT] = xover;
		return w;
	endfunction

endpackage

// [hdl/psl_pulse_if.sv]
// control and pulse signals between status core and pulse generator
`timescale 1ns/10ps
interface psl_pulse_if;
	logic        an_en;
	logic        complete;
	logic [15:0] word;
	logic        pulse;
	modport ctl (output an_en, output complete, output word, input pulse);
	modport gen (input an_en, input complete, input word, output pulse);
endinterface

// [hdl/psl_link_pulse.sv]
// auto-negotiation link pulse burst generator
`timescale 1ns/10ps
module psl_link_pulse
	import psl_pkg::*;
#(
	parameter int P_GAP_SHORT_CYC = GAP_SHORT_CYC,
	parameter int P_GAP_LONG_CYC  = GAP_LONG_CYC,
	parameter int P_BURST_CYC     = BURST_LEN_CYC,
	parameter int P_PERIOD_CYC    = BURST_PER_CYC
) (
	input  wire logic   clk_i,
	input  wire logic   rstn_i,
	psl_pulse_if.gen    pif
);
	logic               run;
	logic               in_burst;
	logic [FRAME_W-1:0] frame_q;
	logic [FRAME_W-1:0] gap_q;
	logic [WIDTH_W-1:0] width_q;
	logic [3:0]         bit_q;
	logic [FRAME_W-1:0] since_q;
	logic               gap_ok_q;
	logic [WIDTH_W-1:0] hi_q;

	assign run       = pif.an_en && !pif.complete;
	assign in_burst  = frame_q < FRAME_W'(P_BURST_CYC);
	assign pif.pulse = width_q != '0;

	// (R10) burst frame timer
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			frame_q <= '0;
		end else if (!run || frame_q == FRAME_W'(P_PERIOD_CYC - 1)) begin
			frame_q <= '0;
		end else begin
			frame_q <= frame_q + 1'b1;
		end
	end

	// (R9) pulse width and spacing
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			width_q <= '0;
			gap_q   <= '0;
			bit_q   <= '0;
		end else if (!run) begin
			width_q <= '0;
			gap_q   <= '0;
			bit_q   <= '0;
		end else begin
			if (width_q != '0) begin
				width_q <= width_q - 1'b1;
			end
			if (frame_q == FRAME_W'(P_PERIOD_CYC - 1)) begin
				gap_q <= '0;
			end else if (in_burst && gap_q == '0) begin
				width_q <= WIDTH_W'(PULSE_WIDTH_CYC);
				// advertised ones get the short spacing
				gap_q   <= pif.word[bit_q] ? FRAME_W'(P_GAP_SHORT_CYC - 1)
					: FRAME_W'(P_GAP_LONG_CYC - 1);
				bit_q   <= bit_q + 1'b1;
			end else if (in_burst) begin
				gap_q <= gap_q - 1'b1;
			end
		end
	end

	// checking aids only
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			since_q  <= '0;
			gap_ok_q <= 1'b0;
			hi_q     <= '0;
		end else begin
			since_q  <= (pif.pulse && hi_q == '0) ? FRAME_W'(1) : since_q + 1'b1;
			gap_ok_q <= (!run || frame_q == FRAME_W'(P_PERIOD_CYC - 1)) ? 1'b0
				: (gap_ok_q || (pif.pulse && hi_q == '0));
			hi_q     <= pif.pulse ? hi_q + 1'b1 : '0;
		end
	end

	a_pulse_width: assert property (@(posedge clk_i) disable iff (!rstn_i) // R9
		$fell(pif.pulse) && $past(run) |-> hi_q == WIDTH_W'(PULSE_WIDTH_CYC))
		else $error("link pulse width wrong");
	a_pulse_gap: assert property (@(posedge clk_i) disable iff (!rstn_i) // R9
		$rose(pif.pulse) && gap_ok_q |-> since_q == FRAME_W'(P_GAP_SHORT_CYC)
		|| since_q == FRAME_W'(P_GAP_LONG_CYC))
		else $error("link pulse spacing wrong");
	a_burst_window: assert property (@(posedge clk_i) disable iff (!rstn_i) // R10
		$rose(pif.pulse) |-> frame_q <= FRAME_W'(P_BURST_CYC))
		else $error("link pulse outside burst");
	a_pulse_stop: assert property (@(posedge clk_i) disable iff (!rstn_i) // R8
		!run |=> !pif.pulse)
		else $error("pulse while negotiation off");
	c_pulse_rise: cover property (@(posedge clk_i) disable iff (!rstn_i)
		$rose(pif.pulse) && gap_ok_q);
	c_burst_wrap: cover property (@(posedge clk_i) disable iff (!rstn_i)
		run && frame_q == FRAME_W'(P_PERIOD_CYC - 1));

endmodule

// [hdl/psl_top.sv]
// phy status registers, management slave and link pulse output
//
// Contract
// (R1) status bits 4,2,1,0: negotiation done, full duplex, 10 Mbps, link up.
// (R2) status low nibble reads 7 at 10 Mbps, 5 at 100 Mbps.
// (R3) status bit 14 shows crossover mode, independent of other bits.
// (R4) partner ability register holds what the remote station advertised.
// (R5) strap levels latched at start-up, readable in two strap registers.
// (R6) active-low reset holds device idle; no management answer during it.
// (R7) clock output is a buffered copy of the reference oscillator input; the code registers it on the rising core clock edge instead.
// (R8) negotiation and automatic crossover enabled after reset without writes.
// (R9) link pulses 100 ns wide, spaced 62 or 125 us on transmit pair.
// (R10) pulses grouped in 2 ms bursts, one burst every 16 ms.
// (R11) management read frames return register contents in frame order.
// (R12) status and strap registers are read-only; writes change nothing.
`timescale 1ns/10ps
module psl_top
	import psl_pkg::*;
#(
	parameter int P_GAP_SHORT_CYC = GAP_SHORT_CYC,
	parameter int P_GAP_LONG_CYC  = GAP_LONG_CYC,
	parameter int P_BURST_CYC     = BURST_LEN_CYC,
	parameter int P_PERIOD_CYC    = BURST_PER_CYC
) (
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	input  wire logic        ref_osc_input_i,
	input  wire logic        mdc_i,
	input  wire logic        mdio_i,
	input  wire logic        link_up_i,
	input  wire logic        speed_100_i,
	input  wire logic        full_duplex_i,
	input  wire logic        an_complete_i,
	input  wire logic        crossover_cabling_mode_i,
	input  wire logic [15:0] partner_ability_i,
	input  wire logic        partner_ability_valid_i,
	input  wire logic [15:0] strap_one_i,
	input  wire logic [15:0] strap_two_i,
	input  wire logic        an_disable_i,
	input  wire logic        mdix_disable_i,
	output logic             mdio_o,
	output logic             mdio_oe_n_o,
	output logic             clk_out_o,
	output logic             tx_pair_positive_o,
	output logic             tx_pair_negative_o,
	output logic             an_enabled_o,
	output logic             mdix_enabled_o
);
	psl_pulse_if pif ();

	psl_mdio_st_t st_q;
	logic         mdc_q;
	logic         mdc_rise;
	logic [5:0]   ones_q;
	logic [4:0]   cnt_q;
	logic [15:0]  sr_q;
	logic [12:0]  hdr;
	logic         rd_q;
	logic [15:0]  reg_q;
	logic [15:0]  dout_q;
	logic [15:0]  stat_q;
	logic [15:0]  lpa_q;
	logic [15:0]  strap1_q;
	logic [15:0]  strap2_q;
	logic         strap_done_q;
	logic [15:0]  ext_ctl_q;
	logic [15:0]  ext_addr_q;
	logic         frame_end;

	function automatic logic [15:0] reg_read(input logic [15:0] addr);
		logic [15:0] v;
		v = 16'h0000;
		case (addr)
			REG_LPA:      v = lpa_q;
			REG_STAT:     v = stat_q;
			REG_STRAP1:   v = strap1_q;
			REG_STRAP2:   v = strap2_q;
			REG_EXT_CTL:  v = ext_ctl_q;
			REG_EXT_ADDR: v = ext_addr_q;
			default:      v = 16'h0000;
		endcase
		return v;
	endfunction

	assign mdc_rise     = mdc_i && !mdc_q;
	assign hdr          = {sr_q[11:0], mdio_i};
	assign frame_end    = mdc_rise && st_q == MS_DATA && cnt_q == DATA_LAST;
	assign pif.an_en    = an_enabled_o;
	assign pif.complete = an_complete_i;
	assign pif.word     = LOCAL_ABILITY;

	psl_link_pulse #(
		.P_GAP_SHORT_CYC (P_GAP_SHORT_CYC),
		.P_GAP_LONG_CYC  (P_GAP_LONG_CYC),
		.P_BURST_CYC     (P_BURST_CYC),
		.P_PERIOD_CYC    (P_PERIOD_CYC)
	) u_pulse (
		.clk_i  (clk_i),
		.rstn_i (rstn_i),
		.pif    (pif.gen)
	);

	// (R1) (R2) (R3) live status word, mdix bit kept apart
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			stat_q <= 16'h0000;
		end else begin
			stat_q <= psl_status_word(link_up_i, speed_100_i, full_duplex_i,
				an_complete_i, crossover_cabling_mode_i);
		end
	end

	// (R4) capture advertised partner word
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			lpa_q <= 16'h0000;
		end else if (partner_ability_valid_i) begin
			lpa_q <= partner_ability_i;
		end
	end

	// (R5) straps caught once, first edge after release
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			strap1_q     <= 16'h0000;
			strap2_q     <= 16'h0000;
			strap_done_q <= 1'b0;
		end else if (!strap_done_q) begin
			strap1_q     <= strap_one_i;
			strap2_q     <= strap_two_i;
			strap_done_q <= 1'b1;
		end
	end

	// (R7) registered copy; can toggle on every rising core clock edge
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			clk_out_o <= 1'b0;
		end else begin
			clk_out_o <= ref_osc_input_i;
		end
	end

	// (R8) enables come up set
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			an_enabled_o   <= 1'b1;
			mdix_enabled_o <= 1'b1;
		end else begin
			an_enabled_o   <= !an_disable_i;
			mdix_enabled_o <= !mdix_disable_i;
		end
	end

	// (R9) drive the transmit pair
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tx_pair_positive_o <= 1'b0;
			tx_pair_negative_o <= 1'b0;
		end else begin
			tx_pair_positive_o <= pif.pulse;
			tx_pair_negative_o <= 1'b0;
		end
	end

	// (R12) only the indirect address pair is writable
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ext_ctl_q  <= 16'h0000;
			ext_addr_q <= 16'h0000;
		end else if (frame_end && !rd_q) begin
			if (reg_q == REG_EXT_CTL) begin
				ext_ctl_q <= {sr_q[14:0], mdio_i};
			end else if (reg_q == REG_EXT_ADDR && ext_ctl_q[15:14] == EXT_FUNC_ADDR) begin
				ext_addr_q <= {sr_q[14:0], mdio_i};
			end
		end
	end

	// (R6) (R11) serial management frame engine, silent in reset
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_q        <= MS_IDLE;
			mdc_q       <= 1'b0;
			ones_q      <= '0;
			cnt_q       <= '0;
			sr_q        <= '0;
			rd_q        <= 1'b0;
			reg_q       <= '0;
			dout_q      <= '0;
			mdio_o      <= 1'b1;
			mdio_oe_n_o <= 1'b1;
		end else begin
			mdc_q <= mdc_i;
			if (mdc_rise) begin
				case (st_q)
					MS_IDLE: begin
						cnt_q <= '0;
						if (mdio_i) begin
							ones_q <= (ones_q == PREAMBLE_LEN) ? ones_q : ones_q + 1'b1;
						end else begin
							ones_q <= '0;
							if (ones_q == PREAMBLE_LEN) begin
								st_q <= MS_HDR;
							end
						end
					end
					MS_HDR: begin
						sr_q  <= {sr_q[14:0], mdio_i};
						cnt_q <= cnt_q + 1'b1;
						if (cnt_q == HDR_LAST) begin
							cnt_q <= '0;
							rd_q  <= hdr[11:10] == OP_READ;
							reg_q <= {11'h000, hdr[4:0]};
							// wrong start bit, address or opcode: ignore frame
							if (hdr[12] && hdr[9:5] == PHY_ADDR
								&& (hdr[11:10] == OP_READ || hdr[11:10] == OP_WRITE)) begin
								st_q <= MS_TA;
							end else begin
								st_q <= MS_IDLE;
							end
							if (hdr[4:0] == REG_EXT_ADDR[4:0] && ext_ctl_q[15:14] != EXT_FUNC_ADDR) begin
								dout_q <= reg_read(ext_addr_q);
							end else begin
								dout_q <= reg_read({11'h000, hdr[4:0]});
							end
						end
					end
					MS_TA: begin
						cnt_q <= cnt_q + 1'b1;
						if (cnt_q == '0) begin
							mdio_o      <= 1'b0;
							mdio_oe_n_o <= !rd_q;
						end else begin
							cnt_q  <= '0;
							st_q   <= MS_DATA;
							mdio_o <= rd_q ? dout_q[15] : 1'b1;
							dout_q <= {dout_q[14:0], 1'b0};
						end
					end
					MS_DATA: begin
						cnt_q  <= cnt_q + 1'b1;
						sr_q   <= {sr_q[14:0], mdio_i};
						mdio_o <= dout_q[15];
						dout_q <= {dout_q[14:0], 1'b0};
						if (cnt_q == DATA_LAST) begin
							st_q        <= MS_IDLE;
							mdio_o      <= 1'b1;
							mdio_oe_n_o <= 1'b1;
						end
					end
					default: begin
						st_q        <= MS_IDLE;
						mdio_oe_n_o <= 1'b1;
					end
				endcase
			end
		end
	end

	a_stat_10m: assert property (@(posedge clk_i) disable iff (!rstn_i) // R2
		rstn_i && link_up_i && full_duplex_i && an_complete_i && !speed_100_i
		|=> stat_q[4:0] == 5'h17)
		else $error("10 Mbps status nibble wrong");
	a_stat_100m: assert property (@(posedge clk_i) disable iff (!rstn_i) // R1
		rstn_i && link_up_i && full_duplex_i && an_complete_i && speed_100_i
		|=> stat_q[4:0] == 5'h15)
		else $error("100 Mbps status bits wrong");
	a_xover_bit: assert property (@(posedge clk_i) disable iff (!rstn_i) // R3
		$changed(crossover_cabling_mode_i) && $stable(speed_100_i) && $stable(link_up_i)
		&& $stable(full_duplex_i) && $stable(an_complete_i)
		|=> $changed(stat_q[STAT_XOVER_BIT]) && $stable(stat_q[4:0]))
		else $error("crossover bit coupled to status");
	a_lpa_hold: assert property (@(posedge clk_i) disable iff (!rstn_i) // R4
		!partner_ability_valid_i |=> $stable(lpa_q))
		else $error("partner ability changed without update");
	a_strap_hold: assert property (@(posedge clk_i) disable iff (!rstn_i) // R5
		strap_done_q |=> $stable(strap1_q) && $stable(strap2_q))
		else $error("strap latch moved");
	a_idle_release: assert property (@(posedge clk_i) disable iff (!rstn_i) // R6
		st_q == MS_IDLE || st_q == MS_HDR |-> mdio_oe_n_o)
		else $error("mdio driven outside answer");
	a_clk_copy: assert property (@(posedge clk_i) disable iff (!rstn_i) // R7
		rstn_i && ref_osc_input_i |=> clk_out_o)
		else $error("clock output not following reference");
	a_auto_on: assert property (@(posedge clk_i) disable iff (!rstn_i) // R8
		!an_disable_i && !mdix_disable_i |=> an_enabled_o && mdix_enabled_o)
		else $error("auto modes not enabled");
	a_read_drive: assert property (@(posedge clk_i) disable iff (!rstn_i) // R11
		st_q == MS_DATA && rd_q |-> !mdio_oe_n_o)
		else $error("read data not driven");
	a_ro_regs: assert property (@(posedge clk_i) disable iff (!rstn_i) // R12
		frame_end && !rd_q && reg_q == REG_STAT |=> $stable(strap1_q) && $stable(lpa_q))
		else $error("read-only register written");
	c_read_frame: cover property (@(posedge clk_i) disable iff (!rstn_i)
		frame_end && rd_q && reg_q == REG_STAT);
	c_write_frame: cover property (@(posedge clk_i) disable iff (!rstn_i)
		frame_end && !rd_q);

endmodule

// [verif/psl_mgmt_station.sv]
// management station model driving mdc and mdio frames
`timescale 1ns/10ps
module psl_mgmt_station
	import psl_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic mdio_w_i,
	output logic      mdc_o,
	output logic      mdio_o,
	output logic      mdio_oe_o
);
	initial begin
		mdc_o     = 1'b0;
		mdio_o    = 1'b1;
		mdio_oe_o = 1'b0;
	end

	// slow mdc, three clk a bit, so the device sees every rise
	task automatic put_bit(input logic b, input logic drv, output logic smp);
		@(posedge clk_i);
		mdc_o     <= 1'b0;
		mdio_o    <= b;
		mdio_oe_o <= drv;
		repeat (2) @(posedge clk_i);
		smp = mdio_w_i;
		mdc_o <= 1'b1;
	endtask

	task automatic frame(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
		output logic [15:0] rd, output logic ta);
		logic [13:0] hdr;
		logic        s;
		hdr = {2'b01, op, PHY_ADDR, ra};
		rd  = 16'h0000;
		for (int i = 0; i < 32; i++) put_bit(1'b1, 1'b1, s);
		for (int i = 13; i >= 0; i--) put_bit(hdr[i], 1'b1, s);
		if (op == OP_READ) begin
			// turnaround and data released, pull-up shows when undriven
			put_bit(1'b1, 1'b0, s);
			put_bit(1'b1, 1'b0, ta);
			for (int i = 15; i >= 0; i--) begin
				put_bit(1'b1, 1'b0, s);
				rd[i] = s;
			end
		end else begin
			put_bit(1'b1, 1'b1, s);
			put_bit(1'b0, 1'b1, ta);
			for (int i = 15; i >= 0; i--) put_bit(wd[i], 1'b1, s);
		end
		@(posedge clk_i);
		mdc_o     <= 1'b0;
		mdio_oe_o <= 1'b0;
	endtask
endmodule

// [verif/tb.sv]
// self-checking bench for the phy status and link pulse block
`timescale 1ns/10ps
module tb;
	import psl_pkg::*;
	localparam int GS = 40;
	localparam int GL = 80;
	localparam int BL = 400;
	localparam int BP = 1600;
	logic        clk_i, rstn_i, ref_osc, link, s100, fdx, anc, xov, pa_v, an_dis, mx_dis;
	logic [15:0] pa, s1, s2, e1, e2, rd, w;
	logic        mdio_w, mdio_d, oe_n, clk_out, txp, txn, an_en, mx_en;
	logic        mdc, st_d, st_oe, ta, ref_h, mon, tx_q;
	int          seed = 32'h88f0a65d;
	int          fails = 0;
	int          checks_done = 0;
	int          cyc = 0;
	int          age = 0;
	int          lr, bs, nb, pr, r, q;

	psl_top #(.P_GAP_SHORT_CYC(GS), .P_GAP_LONG_CYC(GL), .P_BURST_CYC(BL),
		.P_PERIOD_CYC(BP)) uut (
		.clk_i(clk_i), .rstn_i(rstn_i), .ref_osc_input_i(ref_osc), .mdc_i(mdc),
		.mdio_i(mdio_w), .link_up_i(link), .speed_100_i(s100), .full_duplex_i(fdx),
		.an_complete_i(anc), .crossover_cabling_mode_i(xov), .partner_ability_i(pa),
		.partner_ability_valid_i(pa_v), .strap_one_i(s1), .strap_two_i(s2),
		.an_disable_i(an_dis), .mdix_disable_i(mx_dis), .mdio_o(mdio_d),
		.mdio_oe_n_o(oe_n), .clk_out_o(clk_out), .tx_pair_positive_o(txp),
		.tx_pair_negative_o(txn), .an_enabled_o(an_en), .mdix_enabled_o(mx_en));
	psl_mgmt_station st (.clk_i(clk_i), .mdio_w_i(mdio_w), .mdc_o(mdc), .mdio_o(st_d),
		.mdio_oe_o(st_oe));
	// pull-up wins when nobody drives
	assign mdio_w = !oe_n ? mdio_d : (st_oe ? st_d : 1'b1);

	task automatic cmp16(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cmp1(input string nm, input logic e, input logic g);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %b seen %b", nm, e, g);
		end
	endtask
	task automatic cmp_int(input string nm, input int e, input int g);
		checks_done++;
		if (g != e) begin
			fails++;
			$display("Error %s expected %0d seen %0d", nm, e, g);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// v is {link, speed 100, full duplex, done, crossover}
	function automatic logic [15:0] st_exp(input logic [4:0] v);
		logic [15:0] e;
		e = 16'h0000;
		e[0] = v[4];
		e[1] = !v[3];
		e[2] = v[2];
		e[4] = v[1];
		e[14] = v[0];
		return e;
	endfunction
	task automatic rd_reg(input logic [4:0] a, output logic [15:0] v);
		st.frame(OP_READ, a, 16'h0000, v, ta);
	endtask
	task automatic wr_reg(input logic [4:0] a, input logic [15:0] v);
		logic [15:0] d;
		st.frame(OP_WRITE, a, v, d, ta);
	endtask
	task automatic rd_strap(input logic [15:0] a, output logic [15:0] v);
		wr_reg(REG_EXT_CTL[4:0], 16'h0000);
		wr_reg(REG_EXT_ADDR[4:0], a);
		wr_reg(REG_EXT_CTL[4:0], 16'h4000);
		rd_reg(REG_EXT_ADDR[4:0], v);
	endtask

	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc++;
		q = $random(seed);
		ref_osc <= q[0];
		age <= rstn_i ? age + 1 : 0;
		if (cyc > 30000) begin
			fails++;
			end_of_test();
		end
	end
	always @(negedge clk_i) begin
		if (age > 2 && rstn_i) cmp1("clk_out", ref_h, clk_out);
		ref_h = ref_osc;
		cmp1("tx_negative", 1'b0, txn);
		if (mon && txp && !tx_q) begin
			pr = cyc - lr;
			if (lr > 0 && pr < 200) begin
				cmp1("pulse spacing", 1'b1, pr == GS || pr == GL);
				cmp1("burst length", 1'b1, cyc - bs < BL);
			end else begin
				if (bs > 0) cmp_int("burst period", BP, cyc - bs);
				bs = cyc;
				nb++;
			end
			lr = cyc;
		end
		if (mon && !txp && tx_q && lr > 0) cmp_int("pulse width", PULSE_WIDTH_CYC, cyc - lr);
		tx_q = txp;
	end

	initial begin
		{rstn_i, ref_osc, link, s100, fdx, xov, pa_v, an_dis, mx_dis, mon, tx_q} = '0;
		{anc, ref_h} = 2'b10;
		lr = 0;
		bs = 0;
		nb = 0;
		pa = 16'h0000;
		s1 = 16'($random(seed));
		s2 = 16'($random(seed));
		e1 = s1;
		e2 = s2;
		repeat (16) @(posedge clk_i);
		rstn_i <= 1'b1;
		@(posedge clk_i);
		s1 <= ~e1;
		s2 <= ~e2;
		@(negedge clk_i);
		cmp1("an_enabled", 1'b1, an_en);
		cmp1("mdix_enabled", 1'b1, mx_en);
		@(posedge clk_i);
		anc <= 1'b0;
		mon <= 1'b1;
		repeat (4000) @(posedge clk_i);
		mon <= 1'b0;
		cmp_int("bursts", 3, nb);
		an_dis <= 1'b1;
		mx_dis <= 1'b1;
		repeat (3) @(negedge clk_i);
		cmp1("an_enabled", 1'b0, an_en);
		cmp1("mdix_enabled", 1'b0, mx_en);
		repeat (50) @(negedge clk_i) cmp1("tx idle", 1'b0, txp);
		for (int i = 0; i < 10; i++) begin
			@(posedge clk_i);
			r = $random(seed);
			if (i < 2) r = i ? 5'h1f : 5'h16;
			{link, s100, fdx, anc, xov} <= r[4:0];
			@(posedge clk_i);
			rd_reg(REG_STAT[4:0], rd);
			cmp16("status", st_exp(r[4:0]), rd);
			cmp1("turnaround", 1'b0, ta);
		end
		for (int i = 0; i < 2; i++) begin
			@(posedge clk_i);
			pa <= 16'($random(seed));
			pa_v <= 1'b1;
			@(posedge clk_i);
			pa_v <= 1'b0;
			w = pa;
			pa <= ~pa;
			rd_reg(REG_LPA[4:0], rd);
			cmp16("partner ability", w, rd);
		end
		wr_reg(REG_STAT[4:0], 16'hffff);
		rd_reg(REG_STAT[4:0], rd);
		cmp16("status after write", st_exp(r[4:0]), rd);
		wr_reg(REG_LPA[4:0], ~w);
		rd_reg(REG_LPA[4:0], rd);
		cmp16("ability after write", w, rd);
		rd_strap(REG_STRAP1, rd);
		cmp16("strap one", e1, rd);
		rd_strap(REG_STRAP2, rd);
		cmp16("strap two", e2, rd);
		wr_reg(REG_EXT_ADDR[4:0], ~e2);
		rd_reg(REG_EXT_ADDR[4:0], rd);
		cmp16("strap after write", e2, rd);
		rd_reg(5'h1f, rd);
		cmp16("unmapped", 16'h0000, rd);
		@(posedge clk_i);
		rstn_i <= 1'b0;
		rd_reg(REG_STAT[4:0], rd);
		cmp16("read in reset", 16'hffff, rd);
		cmp1("an_enabled in reset", 1'b1, an_en);
		s1 <= 16'($random(seed));
		s2 <= 16'($random(seed));
		@(posedge clk_i);
		e1 = s1;
		e2 = s2;
		rstn_i <= 1'b1;
		@(posedge clk_i);
		s1 <= ~e1;
		s2 <= ~e2;
		rd_strap(REG_STRAP1, rd);
		cmp16("strap one again", e1, rd);
		rd_strap(REG_STRAP2, rd);
		cmp16("strap two again", e2, rd);
		end_of_test();
	end
endmodule
